// [verilog/smc_top.sv]
`timescale 1ns/100ps
// Overview of operation
// - sleep with standby select enters standby
// - standby select refused while watchdog runs
// - ports hold or float per float select
// - entry clears watchdog top bits, reset control
// - entry initialises all serial interface registers
// - pin function and port registers retained
// - control register kept; converter, compare timer cleared
// - exit only by interrupt edge or resets
// - selected interrupt edge restarts oscillation
// - only watchdog clocked until overflow
// - overflow after selected interval marks stable
// - overflow restores clock, exits, takes interrupt
// - power-on reset pin low cancels standby
// - edge select zero detects falling edge
// - edge select one detects rising edge
module smc_top
   import smc_pkg::*;
(
   input  wire logic       core_clk_in,            // 50 MHz system clock
   input  wire logic       sys_rst_in,             // synchronous reset
   input  wire logic       power_on_reset_pin_n_in, // power-on reset pin, low active
   input  wire logic       manual_reset_pin_n_in,  // manual reset pin, low active
   input  wire logic       nmi_pin_in,             // interrupt pin
   input  wire logic       nmi_edge_select_in,     // irq_control_reg edge select
   input  wire logic       sleep_exec_in,          // sleep instruction pulse
   input  wire logic       ctrl_wr_in,             // power_down_control_reg write
   input  wire logic       standby_select_in,      // written standby select
   input  wire logic       port_float_select_in,   // written float select
   input  wire logic       wdog_csr_wr_in,         // watchdog csr write
   input  wire logic [7:0] wdog_csr_wdata_in,      // watchdog csr write data
   output logic            standby_select_out,     // standby select bit
   output logic            port_float_select_out,  // float select bit
   output logic            ports_float_out,        // port drivers off
   output logic            ports_hold_out,         // port latches frozen
   output logic            in_standby_out,         // standby or wake state
   output logic            cpu_halt_out,           // cpu stalled
   output smc_clk_en_t     clk_en_out,             // clock gate enables
   output logic [7:0]      wdog_control_status_out, // watchdog csr image
   output logic [7:0]      wdog_counter_out,       // watchdog counter
   output logic            wdog_reset_control_init_out, // reset control init
   output logic            serial_iface_init_out,  // serial regs init pulse
   output logic            analog_timer_init_out,  // converter and timer init
   output logic            nmi_take_out,           // interrupt exception request
   output logic            por_req_out,            // power-on reset request
   output logic            manual_reset_req_out    // manual reset request
);
   smc_state_t         state_q, state_d;       // sequencer state
   smc_wdog_csr_t      csr_q, csr_d;           // watchdog csr image
   logic [PRESC_W-1:0] presc_q, presc_d;       // watchdog prescaler
   logic [7:0]         cnt_q, cnt_d;           // watchdog counter
   logic               sby_q, sby_d;           // standby select
   logic               hiz_q, hiz_d;           // float select
   logic               init_q, init_d;         // entry init pulse
   logic               take_q, take_d;         // interrupt take pulse
   logic               por_q, por_d;           // power-on reset request
   logic               manual_reset_pin_q, manual_reset_pin_d;         // manual reset request
   logic               nmi_level;              // synchronised pin level
   logic               nmi_edge;               // selected edge pulse
   logic [1:0]         res_sync_q;             // reset pin synchroniser
   logic [1:0]         manual_reset_pin_sync_q;            // manual reset synchroniser
   logic               tick;                   // prescaler expiry

   // interrupt pin synchroniser and edge detector
   smc_edge_sync u_edge (
      .core_clk_in   (core_clk_in),
      .sys_rst_in    (sys_rst_in),
      .pin_in        (nmi_pin_in),
      .rising_sel_in (nmi_edge_select_in),
      .level_out     (nmi_level),
      .edge_out      (nmi_edge)
   );

   // reset pins pass two flip-flops
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         res_sync_q  <= 2'h3;
         manual_reset_pin_sync_q <= 2'h3;
      end
      else
      begin
         res_sync_q  <= {res_sync_q[0], power_on_reset_pin_n_in};
         manual_reset_pin_sync_q <= {manual_reset_pin_sync_q[0], manual_reset_pin_n_in};
      end
   end

   // prescaler expires at the interval chosen before entry
   assign tick = (presc_q == smc_interval(csr_q.clock_select) - 1'b1);

   // next-state and register logic
   always_comb
   begin
      state_d = state_q;
      csr_d   = csr_q;
      presc_d = presc_q;
      cnt_d   = cnt_q;
      sby_d   = sby_q;
      hiz_d   = hiz_q;
      init_d  = 1'b0;
      take_d  = 1'b0;
      por_d   = ~res_sync_q[1];
      manual_reset_pin_d  = res_sync_q[1] & ~manual_reset_pin_sync_q[1];
      // software writes, only while running
      if (state_q == SMC_RUN)
      begin
         if (ctrl_wr_in && !csr_q.run)
         begin
            sby_d = standby_select_in;
            hiz_d = port_float_select_in;
         end
         if (wdog_csr_wr_in)
         begin
            csr_d.overflow     = csr_q.overflow & wdog_csr_wdata_in[WDOG_OVF_BIT];
            csr_d.mode         = wdog_csr_wdata_in[WDOG_MODE_BIT];
            csr_d.run          = wdog_csr_wdata_in[WDOG_RUN_BIT];
            csr_d.clock_select = wdog_csr_wdata_in[WDOG_CKS_MSB:0];
         end
      end
      unique case (state_q)
         // normal execution
         SMC_RUN:
         begin
            if (sleep_exec_in && sby_q)
            begin
               state_d = SMC_STANDBY;
               {csr_d.overflow, csr_d.mode, csr_d.run} = WDOG_TOP_RST;
               init_d  = 1'b1;
               presc_d = '0;
            end
         end
         // clock stopped, waiting for wake-up
         SMC_STANDBY:
         begin
            if (nmi_edge)
               state_d = SMC_WAKE;
         end
         // only watchdog clocked; counter steps up on each prescaler expiry
         SMC_WAKE:
         begin
            presc_d = tick ? '0 : presc_q + 1'b1;
            if (tick)
            begin
               cnt_d = cnt_q + 8'h01;
               if (cnt_q == 8'hFF)
               begin
                  csr_d.overflow = 1'b1;
                  state_d        = SMC_RUN;
                  take_d         = 1'b1;
               end
            end
         end
         default:
            state_d = SMC_RUN;
      endcase
      // resets override and cancel standby
      if (por_d || manual_reset_pin_d)
      begin
         state_d = SMC_RUN;
         take_d  = 1'b0;
      end
      if (por_d)
      begin
         sby_d = 1'b0;
         hiz_d = 1'b0;
         csr_d = '0;
         cnt_d = WDOG_CNT_RST;
      end
   end

   // state registers; control register kept across standby
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         state_q <= SMC_RUN;
         csr_q   <= '0;
         presc_q <= '0;
         cnt_q   <= WDOG_CNT_RST;
         sby_q   <= 1'b0;
         hiz_q   <= 1'b0;
         init_q  <= 1'b0;
         take_q  <= 1'b0;
         por_q   <= 1'b0;
         manual_reset_pin_q  <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         csr_q   <= csr_d;
         presc_q <= presc_d;
         cnt_q   <= cnt_d;
         sby_q   <= sby_d;
         hiz_q   <= hiz_d;
         init_q  <= init_d;
         take_q  <= take_d;
         por_q   <= por_d;
         manual_reset_pin_q  <= manual_reset_pin_d;
      end
   end

   // registered outputs, derived from the next values
   logic       stby_d;
   logic [2:0] clk_d;
   always_comb
   begin
      stby_d = (state_d != SMC_RUN);
      clk_d  = {~stby_d, ~stby_d | (state_d == SMC_WAKE), ~stby_d};
   end

   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         in_standby_out          <= 1'b0;
         cpu_halt_out            <= 1'b0;
         clk_en_out              <= '1;
         ports_float_out         <= 1'b0;
         ports_hold_out          <= 1'b0;
         wdog_control_status_out <= 8'h00;
         wdog_counter_out        <= WDOG_CNT_RST;
         standby_select_out      <= 1'b0;
         port_float_select_out   <= 1'b0;
      end
      else
      begin
         in_standby_out          <= stby_d;
         cpu_halt_out            <= stby_d;
         clk_en_out              <= clk_d;
         ports_float_out         <= stby_d & hiz_d;
         ports_hold_out          <= stby_d;
         wdog_control_status_out <= csr_d;
         wdog_counter_out        <= cnt_d;
         standby_select_out      <= sby_d;
         port_float_select_out   <= hiz_d;
      end
   end

   // pulse outputs straight from their flip-flops
   assign wdog_reset_control_init_out = init_q;
   assign serial_iface_init_out       = init_q;
   assign analog_timer_init_out       = init_q;
   assign nmi_take_out                = take_q;
   assign por_req_out                 = por_q;
   assign manual_reset_req_out        = manual_reset_pin_q;

   logic unused_ok;
   assign unused_ok = nmi_level;
endmodule

// [verilog/smc_pkg.sv]
package smc_pkg;
   // watchdog control/status field positions
   localparam int          WDOG_OVF_BIT   = 7;    // overflow flag
   localparam int          WDOG_MODE_BIT  = 6;    // interval/watchdog mode
   localparam int          WDOG_RUN_BIT   = 5;    // run enable
   localparam int          WDOG_CKS_MSB   = 2;    // clock select high bit
   // reset values of the controlled register fields
   localparam logic [2:0]  WDOG_TOP_RST   = 3'h0; // overflow, mode, enable
   localparam logic [7:0]  WDOG_RSTC_RST  = 8'h1F; // reset control register
   localparam logic [7:0]  SERIAL_RST     = 8'h00; // serial regs except below
   localparam logic [7:0]  SERIAL_BRR_RST = 8'hFF; // bit rate register
   localparam logic [7:0]  SERIAL_SSR_RST = 8'h84; // serial status register
   localparam logic [7:0]  WDOG_CNT_RST   = 8'h00; // counter reset value
   // prescaler: divide ratio per clock select code, as shift amounts
   localparam logic [3:0]  PRESC_SHIFT_0  = 4'h1;
   localparam int          PRESC_W        = 14;

   // run and low power states
   typedef enum logic [1:0] {
      SMC_RUN,
      SMC_STANDBY,
      SMC_WAKE
   } smc_state_t;

   // watchdog register image kept by the sequencer
   typedef struct packed {
      logic       overflow;
      logic       mode;
      logic       run;
      logic [1:0] unused;
      logic [2:0] clock_select;
   } smc_wdog_csr_t;

   // clock gating outputs
   typedef struct packed {
      logic core_clk_en;
      logic wdog_clk_en;
      logic periph_clk_en;
   } smc_clk_en_t;

   // prescaler interval for a clock select code: 2^(code+5) cycles
   function automatic logic [PRESC_W-1:0] smc_interval(input logic [2:0] cks);
      logic [PRESC_W-1:0] v;
      v = {{(PRESC_W-1){1'b0}}, 1'b1};
      v = v << (4'(cks) + PRESC_SHIFT_0 + 4'h4);
      return v;
   endfunction
endpackage

// [verilog/smc_edge_sync.sv]
`timescale 1ns/100ps
// synchronises the interrupt pin and detects the selected edge
module smc_edge_sync
   import smc_pkg::*;
(
   input  wire logic core_clk_in,     // system clock
   input  wire logic sys_rst_in,      // synchronous reset
   input  wire logic pin_in,          // asynchronous pin
   input  wire logic rising_sel_in,   // 1: rising edge, 0: falling edge
   output logic      level_out,       // synchronised level
   output logic      edge_out         // one-cycle pulse on selected edge
);
   logic [2:0] sync_q;   // two synchroniser stages plus history
   logic [2:0] sync_d;
   logic       edge_q;
   logic       edge_d;

   // next values: shift in pin, compare stable stages only
   always_comb
   begin
      sync_d = {sync_q[1:0], pin_in};
      if (rising_sel_in)
         edge_d = sync_q[1] & ~sync_q[2];
      else
         edge_d = ~sync_q[1] & sync_q[2];
   end

   // synchroniser shifts through reset, so its history holds real pin levels
   // and no false edge follows the release of reset
   always_ff @(posedge core_clk_in)
   begin
      sync_q <= sync_d;
   end

   // edge register, cleared by reset
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         edge_q <= 1'b0;
      else
         edge_q <= edge_d;
   end

   assign level_out = sync_q[2];
   assign edge_out  = edge_q;
endmodule

// [verif/smc_checker_asserts.sv]
`timescale 1ns/100ps
// port watcher for the standby sequencer
module smc_checker
   import smc_pkg::*;
(
   input wire logic        core_clk_in,
   input wire logic        sys_rst_in,
   input wire logic        sleep_exec_in,
   input wire logic        ctrl_wr_in,
   input wire logic        standby_select_out,
   input wire logic        port_float_select_out,
   input wire logic        ports_float_out,
   input wire logic        in_standby_out,
   input wire logic        cpu_halt_out,
   input wire smc_clk_en_t clk_en_out,
   input wire logic [7:0]  wdog_control_status_out,
   input wire logic        wdog_reset_control_init_out,
   input wire logic        serial_iface_init_out,
   input wire logic        analog_timer_init_out,
   input wire logic        nmi_take_out,
   input wire logic        por_req_out,
   input wire logic        manual_reset_req_out
);
   // one clock domain
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);

   standby_entry_a: assert property (
      sleep_exec_in && standby_select_out && !in_standby_out
      |=> in_standby_out && clk_en_out == 3'h0) else $error("standby not entered");
   select_refuse_a: assert property (
      ctrl_wr_in && wdog_control_status_out[WDOG_RUN_BIT]
      |=> $stable(standby_select_out)) else $error("select written while watchdog runs");
   port_float_a: assert property (
      ports_float_out == (in_standby_out && port_float_select_out))
      else $error("port float wrong");
   entry_init_a: assert property (
      $rose(in_standby_out) |-> wdog_reset_control_init_out
      && serial_iface_init_out && analog_timer_init_out) else $error("init pulse missing");
   wdog_clear_a: assert property (
      $rose(in_standby_out) |-> wdog_control_status_out[7:5] == 3'h0
      && $stable(wdog_control_status_out[2:0])) else $error("watchdog bits wrong");
   ctrl_keep_a: assert property (
      in_standby_out ##1 in_standby_out |-> $stable(standby_select_out))
      else $error("control bits lost");
   exit_cause_a: assert property (
      $fell(in_standby_out) |-> nmi_take_out || por_req_out || manual_reset_req_out)
      else $error("exit without cause");
   wdog_only_a: assert property (
      clk_en_out == 3'h2 |-> cpu_halt_out && in_standby_out)
      else $error("cpu runs during settle");
   nmi_take_a: assert property (
      nmi_take_out |-> clk_en_out == 3'h7 && !in_standby_out
      && $past(clk_en_out) == 3'h2) else $error("wake end wrong");
   por_cancel_a: assert property (
      por_req_out |-> ##[0:2] !in_standby_out)
      else $error("reset kept standby");
endmodule

// [verif/smc_pin_model.sv]
`timescale 1ns/100ps
// far side: interrupt source and the two reset pins
module smc_pin_model (
   input  wire logic core_clk_in,
   output logic      nmi_pin_out,
   output logic      por_n_out,
   output logic      mrst_n_out
);
   // pins idle: resets released, interrupt low
   initial
   begin
      nmi_pin_out = 1'b0;
      por_n_out = 1'b1;
      mrst_n_out = 1'b1;
   end
   // level set off the sampling edge; bench keeps level per wake polarity
   task automatic set_nmi(input logic v);
      @(negedge core_clk_in);
      nmi_pin_out = v;
   endtask
   // reset pin levels, low active
   task automatic set_rst(input logic por_n, input logic mrst_n);
      @(negedge core_clk_in);
      por_n_out = por_n;
      mrst_n_out = mrst_n;
   endtask
endmodule

// [verif/standby_mode_controller_test.sv]
`timescale 1ns/100ps
// bench for the standby sequencer
module standby_mode_controller_test;
   logic                 clk, rst, nsel, sleep, cwr, sel, flt, wwr;
   logic [7:0]           wd, csr_o, cnt_o;
   logic                 sel_o, flt_o, pf, ph, stby, halt, take, por_r, mr_r, wi, si, ai;
   wire logic            nmi, por_n, mrst_n;
   smc_pkg::smc_clk_en_t clken;
   int                   errors, samples_checked, n;

   smc_top dut_u (.core_clk_in(clk), .sys_rst_in(rst), .power_on_reset_pin_n_in(por_n),
      .manual_reset_pin_n_in(mrst_n), .nmi_pin_in(nmi), .nmi_edge_select_in(nsel),
      .sleep_exec_in(sleep), .ctrl_wr_in(cwr), .standby_select_in(sel),
      .port_float_select_in(flt), .wdog_csr_wr_in(wwr), .wdog_csr_wdata_in(wd),
      .standby_select_out(sel_o), .port_float_select_out(flt_o), .ports_float_out(pf),
      .ports_hold_out(ph), .in_standby_out(stby), .cpu_halt_out(halt), .clk_en_out(clken),
      .wdog_control_status_out(csr_o), .wdog_counter_out(cnt_o),
      .wdog_reset_control_init_out(wi), .serial_iface_init_out(si),
      .analog_timer_init_out(ai), .nmi_take_out(take), .por_req_out(por_r),
      .manual_reset_req_out(mr_r));
   smc_pin_model model_u (.core_clk_in(clk), .nmi_pin_out(nmi), .por_n_out(por_n),
      .mrst_n_out(mrst_n));

   // 50 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one-cycle strobe: 0 csr write, 1 control write, 2 sleep
   task automatic pulse(input int k, input logic [7:0] d);
      @(negedge clk);
      wd = d;
      sel = d[1];
      flt = d[0];
      wwr = (k == 0);
      cwr = (k == 1);
      sleep = (k == 2);
      @(negedge clk);
      wwr = 1'b0;
      cwr = 1'b0;
      sleep = 1'b0;
   endtask
   // bounded wait for the interrupt take pulse
   task automatic wait_take(output int c);
      c = 0;
      while (take !== 1'b1 && c < 17000)
      begin
         @(negedge clk);
         c++;
      end
      check(take, 1'b1);
   endtask
   // verdict
   task automatic report_and_stop;
      if (errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard
   initial
   begin
      repeat (60000) @(posedge clk);
      errors++;
      report_and_stop;
   end
   // main sequence
   initial
   begin
      {rst, nsel, sleep, cwr, sel, flt, wwr, wd} = {7'h60, 8'h00};
      errors = 0;
      samples_checked = 0;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      check(clken, 3'h7);
      pulse(0, 8'h21);
      pulse(1, 8'h03);
      check(sel_o, 1'b0);
      pulse(0, 8'h01);
      pulse(1, 8'h03);
      check({sel_o, flt_o}, 2'h3);
      model_u.set_nmi(1'b0);
      pulse(2, 8'h00);
      check({stby, halt, clken}, 5'h18);
      check({pf, ph}, 2'h3);
      check({wi, si, ai}, 3'h7);
      check(csr_o, 8'h01);
      repeat (100) @(negedge clk);
      check({stby, clken}, 4'h8);
      model_u.set_nmi(1'b1);
      repeat (6) @(negedge clk);
      check({halt, clken}, 4'hA);
      wait_take(n);
      check(n >= 16300 && n <= 16400, 1'b1);
      check({stby, clken, csr_o[7]}, 5'h0F);
      check({sel_o, flt_o}, 2'h3);
      nsel = 1'b0;
      pulse(2, 8'h00);
      check({stby, csr_o}, 9'h101);
      model_u.set_nmi(1'b0);
      // three prescaler periods into the settle, counter stepped three times
      repeat (200) @(negedge clk);
      check(cnt_o, 8'h03);
      wait_take(n);
      check(n >= 16150 && n <= 16250, 1'b1);
      model_u.set_nmi(1'b1);
      pulse(2, 8'h00);
      model_u.set_rst(1'b0, 1'b1);
      repeat (4) @(negedge clk);
      check({por_r, stby}, 2'h2);
      model_u.set_rst(1'b1, 1'b1);
      repeat (4) @(negedge clk);
      pulse(0, 8'h01);
      pulse(1, 8'h02);
      pulse(2, 8'h00);
      check({pf, ph, stby}, 3'h3);
      model_u.set_rst(1'b1, 1'b0);
      repeat (4) @(negedge clk);
      check({mr_r, stby}, 2'h2);
      model_u.set_rst(1'b1, 1'b1);
      repeat (4) @(negedge clk);
      report_and_stop;
   end
endmodule

bind smc_top smc_checker chk_u (.*);
